// File: fault_reaction_eval.sv
`timescale 1ns/1ps
`default_nettype none
module fault_reaction_eval import fault_reaction_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Reaction setting and detector level
  input wire reaction_s reaction,
  input wire logic faultLevel,
  // Decoded response
  output logic faultEvent,
  output logic shutReq,
  output logic retryOk
);

  logic prev_reg;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= faultLevel;
    end
  end

  // The slow result is already averaged, so no filter sits here.
  assign faultEvent = faultLevel & ~prev_reg;
  assign shutReq = faultEvent && (reaction.action != ACTION_CONTINUE);
  assign retryOk = (reaction.retry != RETRY_NONE);

endmodule // fault_reaction_eval
`default_nettype wire

// File: fault_reaction_pkg.sv
`default_nettype none
package fault_reaction_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_MHZ = 10;
  localparam int RETRY_WAIT_US = 100;
  localparam int RETRY_WAIT_CYCLES = RETRY_WAIT_US * CLOCK_MHZ;

  // ----------------------------------------------------------------
  // Fault sources
  // ----------------------------------------------------------------
  localparam int NUM_FAULTS = 5;
  localparam int F_OT = 0;
  localparam int F_UT = 1;
  localparam int F_VIN_OV = 2;
  localparam int F_VIN_UV = 3;
  localparam int F_TON = 4;

  // ----------------------------------------------------------------
  // Reaction register layout
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] action;
    logic [2:0] retry;
    logic [2:0] delay;
  } reaction_s;

  localparam logic [1:0] ACTION_CONTINUE = 2'h0;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] DELAY_FIXED = 3'h0;
  localparam logic [7:0] REACTION_RESET = 8'h80;
  localparam logic [2:0] RETRY_COUNT_RESET = 3'h1;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_OT_REACTION = 8'h10;
  localparam logic [7:0] CMD_UT_REACTION = 8'h11;
  localparam logic [7:0] CMD_VIN_OV_REACTION = 8'h12;
  localparam logic [7:0] CMD_VIN_UV_REACTION = 8'h13;
  localparam logic [7:0] CMD_TON_REACTION = 8'h14;
  localparam logic [7:0] CMD_RETRY_COUNT = 8'h15;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h20;
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h21;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h22;
  localparam logic [7:0] CMD_STATUS_VOUT = 8'h23;
  localparam logic [7:0] CMD_STATUS_INPUT = 8'h24;
  localparam logic [7:0] CMD_STATUS_TEMP = 8'h25;

  // ----------------------------------------------------------------
  // Status bit positions
  // ----------------------------------------------------------------
  localparam int SB_OFF = 6;
  localparam int SB_VIN_UV = 3;
  localparam int SB_TEMP = 2;
  localparam int SB_HIGH_BYTE = 0;
  localparam int SWH_VOUT = 7;
  localparam int SWH_INPUT = 5;
  localparam int SI_VIN_OV = 7;
  localparam int SI_VIN_UV = 4;
  localparam int ST_OT = 7;
  localparam int ST_UT = 4;
  localparam int SV_TON_MAX = 2;

  typedef struct packed {
    logic [7:0] sbyte;
    logic [7:0] wordHigh;
    logic [7:0] vout;
    logic [7:0] input_;
    logic [7:0] temp;
  } status_s;

  typedef enum logic [2:0] {
    CH_IDLE, CH_RUN, CH_SEQ_OFF, CH_DECIDE, CH_RETRY_WAIT, CH_LATCHED
  } chan_state_e;

endpackage
`default_nettype wire

// File: slow_fault_reaction.sv
// Contract
// - Slow faults used undeglitched
// - Slow fault sets byte, word, detail bits
// - Slow fault pulls host alert low
// - Action 00 keeps channel running
// - Action 01-11 shuts down or sequences off
// - Retry 000 never restarts
// - Nonzero retry restarts up to global limit
// - Delay field always reads zero
// - Timeout sets high-byte summary bit
// - Timeout sets vout word and detail bits
// - Timeout pulls host alert low
// - Timeout action shuts down or sequences off; code keeps channel running on action 00
// - Timeout retry 000 never restarts
// - Fault off latched until toggle, command, bias
// - Clear faults keeps latched off state
`timescale 1ns/1ps
`default_nettype none
module slow_fault_reaction import fault_reaction_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Command port
  input wire logic cmdWrite,
  input wire logic cmdRead,
  input wire logic [7:0] cmdCode,
  input wire logic [7:0] cmdWdata,
  output logic [15:0] cmdRdata,
  // Slow detector levels and start-up timeout
  input wire logic overTemp,
  input wire logic underTemp,
  input wire logic vinOver,
  input wire logic vinUnder,
  input wire logic startupTimeout,
  // Channel control
  input wire logic channelOnPin,
  input wire logic biasOkPin,
  input wire logic operationOn,
  input wire logic onOffCmdPulse,
  input wire logic seqOffMode,
  input wire logic [15:0] toffDelayCycles,
  // Channel and alert outputs
  output logic channelEnable,
  output logic seqOffActive,
  output logic channelLatched,
  output logic hostAlertNOut,
  output logic hostAlertNOe
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pinMeta_reg, pinSync_reg, pinLast_reg;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pinMeta_reg <= 2'h0;
      pinSync_reg <= 2'h0;
      pinLast_reg <= 2'h0;
    end else begin
      pinMeta_reg <= {biasOkPin, channelOnPin};
      pinSync_reg <= pinMeta_reg;
      pinLast_reg <= pinSync_reg;
    end
  end

  logic onPin, biasOk, pinToggle, onCmd;
  assign onPin = pinSync_reg[0];
  assign biasOk = pinSync_reg[1];
  assign pinToggle = pinSync_reg[0] ^ pinLast_reg[0];
  assign onCmd = onPin && operationOn && biasOk;

  // ----------------------------------------------------------------
  // Reaction registers
  // ----------------------------------------------------------------
  reaction_s [NUM_FAULTS-1:0] reaction_reg;
  logic [2:0] retryLimit_reg;
  logic [NUM_FAULTS-1:0] faultLevel, faultEvent, shutReq, retryOk;
  logic [NUM_FAULTS-1:0] codeHit;

  assign faultLevel = {startupTimeout, vinUnder, vinOver, underTemp,
                       overTemp};
  assign codeHit = {cmdCode == CMD_TON_REACTION,
                    cmdCode == CMD_VIN_UV_REACTION,
                    cmdCode == CMD_VIN_OV_REACTION,
                    cmdCode == CMD_UT_REACTION,
                    cmdCode == CMD_OT_REACTION};

  genvar g;
  generate
    for (g = 0; g < NUM_FAULTS; g++) begin : gFault
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          reaction_reg[g] <= REACTION_RESET;
        end else if (cmdWrite && codeHit[g]) begin
          reaction_reg[g] <= {cmdWdata[7:3], DELAY_FIXED};
        end
      end

      fault_reaction_eval uEval (
        .clock(clock),
        .rstn(rstn),
        .reaction(reaction_reg[g]),
        .faultLevel(faultLevel[g]),
        .faultEvent(faultEvent[g]),
        .shutReq(shutReq[g]),
        .retryOk(retryOk[g])
      );
    end
  endgenerate

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      retryLimit_reg <= RETRY_COUNT_RESET;
    end else if (cmdWrite && cmdCode == CMD_RETRY_COUNT) begin
      retryLimit_reg <= cmdWdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Status and alert
  // ----------------------------------------------------------------
  status_s status_reg, statusSet;
  logic alert_reg, clearFaults;
  assign clearFaults = cmdWrite && cmdCode == CMD_CLEAR_FAULTS;

  always_comb begin
    statusSet = '0;
    statusSet.temp[ST_OT] = faultEvent[F_OT];
    statusSet.temp[ST_UT] = faultEvent[F_UT];
    statusSet.sbyte[SB_TEMP] = faultEvent[F_OT] | faultEvent[F_UT];
    statusSet.input_[SI_VIN_OV] = faultEvent[F_VIN_OV];
    statusSet.input_[SI_VIN_UV] = faultEvent[F_VIN_UV];
    statusSet.sbyte[SB_VIN_UV] = faultEvent[F_VIN_UV];
    statusSet.wordHigh[SWH_INPUT] = faultEvent[F_VIN_OV] |
                                    faultEvent[F_VIN_UV];
    statusSet.sbyte[SB_HIGH_BYTE] = faultEvent[F_VIN_OV] |
                                    faultEvent[F_TON];
    statusSet.wordHigh[SWH_VOUT] = faultEvent[F_TON];
    statusSet.vout[SV_TON_MAX] = faultEvent[F_TON];
  end

  // A new fault in the clearing cycle survives the clear.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      status_reg <= '0;
    end else begin
      status_reg <= (clearFaults ? '0 : status_reg) | statusSet;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      alert_reg <= 1'b0;
    end else begin
      alert_reg <= (alert_reg && !clearFaults) || (|faultEvent);
    end
  end

  assign hostAlertNOut = 1'b0;
  assign hostAlertNOe = alert_reg;

  // ----------------------------------------------------------------
  // Channel state machine
  // ----------------------------------------------------------------
  chan_state_e state_reg, state_next;
  logic [15:0] count_reg, count_next;
  logic [2:0] attempts_reg, attempts_next;
  logic retryAllowed_reg, retryAllowed_next;
  logic shutAny, noRetryHit, release_;

  assign shutAny = |shutReq;
  // Any shutting source that forbids retry wins over the others.
  assign noRetryHit = |(shutReq & ~retryOk);
  assign release_ = pinToggle || onOffCmdPulse || !biasOk;

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    attempts_next = attempts_reg;
    retryAllowed_next = retryAllowed_reg;
    case (state_reg)
      CH_IDLE: begin
        attempts_next = 3'h0;
        if (onCmd) begin
          state_next = CH_RUN;
        end
      end
      CH_RUN: begin
        if (!onCmd) begin
          state_next = CH_IDLE;
        end else if (shutAny) begin
          retryAllowed_next = !noRetryHit;
          count_next = toffDelayCycles;
          state_next = seqOffMode ? CH_SEQ_OFF : CH_DECIDE;
        end
      end
      CH_SEQ_OFF: begin
        if (shutAny && noRetryHit) begin
          retryAllowed_next = 1'b0;
        end
        if (count_reg == 16'h0000) begin
          state_next = CH_DECIDE;
        end else begin
          count_next = count_reg - 16'h0001;
        end
      end
      CH_DECIDE: begin
        if (retryAllowed_reg && attempts_reg < retryLimit_reg) begin
          attempts_next = attempts_reg + 3'h1;
          count_next = 16'(RETRY_WAIT_CYCLES);
          state_next = CH_RETRY_WAIT;
        end else begin
          state_next = CH_LATCHED;
        end
      end
      CH_RETRY_WAIT: begin
        if (!onCmd) begin
          state_next = CH_IDLE;
        end else if (shutAny) begin
          // A fault whose action is to continue does not end the retries.
          state_next = CH_LATCHED;
        end else if (count_reg == 16'h0000) begin
          state_next = CH_RUN;
        end else begin
          count_next = count_reg - 16'h0001;
        end
      end
      CH_LATCHED: begin
        if (release_) begin
          state_next = CH_IDLE;
        end
      end
      default: begin
        state_next = CH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= CH_IDLE;
      count_reg <= 16'h0000;
      attempts_reg <= 3'h0;
      retryAllowed_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      attempts_reg <= attempts_next;
      retryAllowed_reg <= retryAllowed_next;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      channelEnable <= 1'b0;
      seqOffActive <= 1'b0;
      channelLatched <= 1'b0;
    end else begin
      channelEnable <= (state_next == CH_RUN) ||
                       (state_next == CH_SEQ_OFF);
      seqOffActive <= (state_next == CH_SEQ_OFF);
      channelLatched <= (state_next == CH_LATCHED);
    end
  end

  // ----------------------------------------------------------------
  // Command read
  // ----------------------------------------------------------------
  logic [7:0] liveByte;
  assign liveByte = status_reg.sbyte | {1'b0, !channelEnable, 6'h00};

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cmdRdata <= 16'h0000;
    end else if (cmdRead) begin
      cmdRdata <= 16'h0000;
      for (int i = 0; i < NUM_FAULTS; i++) begin
        if (codeHit[i]) begin
          cmdRdata <= {8'h00, reaction_reg[i]};
        end
      end
      case (cmdCode)
        CMD_RETRY_COUNT: cmdRdata <= {13'h0000, retryLimit_reg};
        CMD_STATUS_BYTE: cmdRdata <= {8'h00, liveByte};
        CMD_STATUS_WORD: cmdRdata <= {status_reg.wordHigh, liveByte};
        CMD_STATUS_VOUT: cmdRdata <= {8'h00, status_reg.vout};
        CMD_STATUS_INPUT: cmdRdata <= {8'h00, status_reg.input_};
        CMD_STATUS_TEMP: cmdRdata <= {8'h00, status_reg.temp};
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_alert_on_fault;
    @(posedge clock) disable iff (!rstn)
    (|faultEvent[F_VIN_UV:F_OT]) |=> hostAlertNOe;
  endproperty
  a_alert_on_fault: assert property (p_alert_on_fault)
    else $error("slow fault did not assert alert");

  property p_temp_status;
    @(posedge clock) disable iff (!rstn)
    faultEvent[F_OT] |=> status_reg.temp[ST_OT] && status_reg.sbyte[SB_TEMP];
  endproperty
  a_temp_status: assert property (p_temp_status)
    else $error("over temperature status not set");

  property p_ton_status;
    @(posedge clock) disable iff (!rstn)
    faultEvent[F_TON] |=> status_reg.sbyte[SB_HIGH_BYTE] &&
      status_reg.wordHigh[SWH_VOUT] && status_reg.vout[SV_TON_MAX] &&
      hostAlertNOe;
  endproperty
  a_ton_status: assert property (p_ton_status)
    else $error("timeout status or alert missing");

  property p_continue;
    @(posedge clock) disable iff (!rstn)
    (state_reg == CH_RUN && onCmd && !shutAny) ##1 onCmd
      |-> channelEnable;
  endproperty
  a_continue: assert property (p_continue)
    else $error("channel dropped without shutdown request");

  property p_immediate_off;
    @(posedge clock) disable iff (!rstn)
    (state_reg == CH_RUN && onCmd && shutAny && !seqOffMode)
      |=> !channelEnable [*2];
  endproperty
  a_immediate_off: assert property (p_immediate_off)
    else $error("immediate shutdown did not disable channel");

  property p_latched_holds;
    @(posedge clock) disable iff (!rstn)
    (state_reg == CH_LATCHED && !release_) |=> !channelEnable;
  endproperty
  a_latched_holds: assert property (p_latched_holds)
    else $error("latched channel turned on");

  property p_no_retry;
    @(posedge clock) disable iff (!rstn)
    (state_reg == CH_DECIDE && !retryAllowed_reg) |=> channelLatched;
  endproperty
  a_no_retry: assert property (p_no_retry)
    else $error("no-retry shutdown did not latch");

  property p_retry_limit;
    @(posedge clock) disable iff (!rstn)
    $rose(state_reg == CH_RETRY_WAIT) |-> attempts_reg <= retryLimit_reg &&
      attempts_reg != 3'h0;
  endproperty
  a_retry_limit: assert property (p_retry_limit)
    else $error("retry attempt beyond limit");

  property p_delay_zero;
    @(posedge clock) disable iff (!rstn)
    (cmdRead && |codeHit) |=> cmdRdata[2:0] == DELAY_FIXED;
  endproperty
  a_delay_zero: assert property (p_delay_zero)
    else $error("delay field read nonzero");

  property p_clear_keeps_latch;
    @(posedge clock) disable iff (!rstn)
    (clearFaults && state_reg == CH_LATCHED && !release_) |=>
      channelLatched && (!hostAlertNOe || $past(|faultEvent));
  endproperty
  a_clear_keeps_latch: assert property (p_clear_keeps_latch)
    else $error("clear faults changed latch or left alert");

endmodule // slow_fault_reaction
`default_nettype wire

// File: supply_side_model.sv
`timescale 1ns/1ps
`default_nettype none
module supply_side_model import fault_reaction_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Fault requests from the bench, one bit a source
  input wire logic [NUM_FAULTS-1:0] faultReq,
  // Alert pin as split by the device
  input wire logic hostAlertNOut,
  input wire logic hostAlertNOe,
  // Detector levels toward the device
  output logic overTemp,
  output logic underTemp,
  output logic vinOver,
  output logic vinUnder,
  output logic startupTimeout,
  // Alert level as the host sees it
  output logic hostAlertN
);
  // ----------------------------------------------------------------
  // Detector levels
  // ----------------------------------------------------------------
  logic [NUM_FAULTS-1:0] level_reg;

  // Levels change only on the clock, as a slow converter result would.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      level_reg <= '0;
    end else begin
      level_reg <= faultReq;
    end
  end

  assign overTemp = level_reg[F_OT];
  assign underTemp = level_reg[F_UT];
  assign vinOver = level_reg[F_VIN_OV];
  assign vinUnder = level_reg[F_VIN_UV];
  // Shorts at start-up are caught only by the start-up timeout.
  assign startupTimeout = level_reg[F_TON];

  // ----------------------------------------------------------------
  // Alert line
  // ----------------------------------------------------------------
  // The line has a pull-up, so an undriven pin reads high.
  assign hostAlertN = hostAlertNOe ? hostAlertNOut : 1'b1;
endmodule // supply_side_model
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb import fault_reaction_pkg::*; ;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic cmdWrite = 1'b0;
  logic cmdRead = 1'b0;
  logic [7:0] cmdCode = 8'h00;
  logic [7:0] cmdWdata = 8'h00;
  logic [15:0] cmdRdata;
  logic [NUM_FAULTS-1:0] faultReq = '0;
  logic channelOnPin = 1'b0;
  logic biasOkPin = 1'b0;
  logic operationOn = 1'b0;
  logic onOffCmdPulse = 1'b0;
  logic seqOffMode = 1'b0;
  logic [15:0] toffDelayCycles = 16'h0000;
  logic overTemp, underTemp, vinOver, vinUnder, startupTimeout;
  logic channelEnable, seqOffActive, channelLatched;
  logic hostAlertNOut, hostAlertNOe, hostAlertN;
  logic [15:0] rd;
  logic [15:0] exp16;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;

  slow_fault_reaction dut (.clock(clock), .rstn(rstn),
    .cmdWrite(cmdWrite), .cmdRead(cmdRead), .cmdCode(cmdCode),
    .cmdWdata(cmdWdata), .cmdRdata(cmdRdata), .overTemp(overTemp),
    .underTemp(underTemp), .vinOver(vinOver), .vinUnder(vinUnder),
    .startupTimeout(startupTimeout), .channelOnPin(channelOnPin),
    .biasOkPin(biasOkPin), .operationOn(operationOn),
    .onOffCmdPulse(onOffCmdPulse), .seqOffMode(seqOffMode),
    .toffDelayCycles(toffDelayCycles), .channelEnable(channelEnable),
    .seqOffActive(seqOffActive), .channelLatched(channelLatched),
    .hostAlertNOut(hostAlertNOut), .hostAlertNOe(hostAlertNOe));

  supply_side_model side (.clock(clock), .rstn(rstn), .faultReq(faultReq),
    .hostAlertNOut(hostAlertNOut), .hostAlertNOe(hostAlertNOe),
    .overTemp(overTemp), .underTemp(underTemp), .vinOver(vinOver),
    .vinUnder(vinUnder), .startupTimeout(startupTimeout),
    .hostAlertN(hostAlertN));

  always #50 clock = ~clock;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("Checks run %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // The whole run needs under 9000 cycles; a hang stops well after that.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic chkVal(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkBit(input logic got, input logic exp);
    chkVal({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #10;
  endtask

  // Each strobe is followed by an idle cycle, so strobes never merge.
  task automatic wrCmd(input logic [7:0] code, input logic [7:0] data);
    cmdWrite = 1'b1;
    cmdCode = code;
    cmdWdata = data;
    tick(1);
    cmdWrite = 1'b0;
    tick(1);
  endtask

  task automatic rdCmd(input logic [7:0] code, output logic [15:0] data);
    cmdRead = 1'b1;
    cmdCode = code;
    tick(1);
    cmdRead = 1'b0;
    tick(1);
    data = cmdRdata;
  endtask

  task automatic waitSig(input int sel, input logic val, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      if ((sel == 0 ? channelEnable : channelLatched) === val) break;
      tick(1);
    end
  endtask

  function automatic logic [15:0] expWord(input int src);
    logic [15:0] w;
    w = 16'h0000;
    case (src)
      F_OT, F_UT: w[SB_TEMP] = 1'b1;
      F_VIN_OV: begin
        w[SB_HIGH_BYTE] = 1'b1;
        w[8 + SWH_INPUT] = 1'b1;
      end
      F_VIN_UV: begin
        w[SB_VIN_UV] = 1'b1;
        w[8 + SWH_INPUT] = 1'b1;
      end
      default: begin
        w[SB_HIGH_BYTE] = 1'b1;
        w[8 + SWH_VOUT] = 1'b1;
      end
    endcase
    return w;
  endfunction

  // Upper byte is the detail command, lower byte the expected bit.
  function automatic logic [15:0] expDetail(input int src);
    logic [15:0] d;
    case (src)
      F_OT: d = {CMD_STATUS_TEMP, 8'h01 << ST_OT};
      F_UT: d = {CMD_STATUS_TEMP, 8'h01 << ST_UT};
      F_VIN_OV: d = {CMD_STATUS_INPUT, 8'h01 << SI_VIN_OV};
      F_VIN_UV: d = {CMD_STATUS_INPUT, 8'h01 << SI_VIN_UV};
      default: d = {CMD_STATUS_VOUT, 8'h01 << SV_TON_MAX};
    endcase
    return d;
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] v;
    int i;
    int n;
    void'($urandom(60));
    tick(2);
    rstn = 1'b1;
    for (i = 0; i < NUM_FAULTS; i++) begin
      rdCmd(CMD_OT_REACTION + 8'(i), rd);
      chkVal(rd, {8'h00, REACTION_RESET});
      v = 8'($urandom);
      wrCmd(CMD_OT_REACTION + 8'(i), v);
      rdCmd(CMD_OT_REACTION + 8'(i), rd);
      chkVal(rd, {8'h00, v & 8'hF8});
    end
    rdCmd(CMD_RETRY_COUNT, rd);
    chkVal(rd, {13'h0000, RETRY_COUNT_RESET});
    rdCmd(8'h3C, rd);
    chkVal(rd, 16'h0000);
    biasOkPin = 1'b1;
    channelOnPin = 1'b1;
    operationOn = 1'b1;
    waitSig(0, 1'b1, 20);
    chkBit(channelEnable, 1'b1);
    // Action continue on every source: flags only, channel untouched.
    for (i = 0; i < NUM_FAULTS; i++) begin
      wrCmd(CMD_OT_REACTION + 8'(i), 8'h00);
      faultReq[i] = 1'b1;
      tick(4);
      chkBit(hostAlertN, 1'b0);
      tick(20);
      chkBit(channelEnable, 1'b1);
      rdCmd(CMD_STATUS_WORD, rd);
      chkVal(rd, expWord(i));
      exp16 = expDetail(i);
      rdCmd(exp16[15:8], rd);
      chkVal({8'h00, rd[7:0]}, {8'h00, exp16[7:0]});
      faultReq[i] = 1'b0;
      wrCmd(CMD_CLEAR_FAULTS, 8'h00);
      chkBit(hostAlertN, 1'b1);
      rdCmd(CMD_STATUS_WORD, rd);
      chkVal(rd, 16'h0000);
    end
    // Immediate shutdown without retry stays latched past a retry wait.
    wrCmd(CMD_OT_REACTION, 8'h80);
    faultReq[F_OT] = 1'b1;
    tick(6);
    chkBit(channelEnable, 1'b0);
    chkBit(channelLatched, 1'b1);
    faultReq[F_OT] = 1'b0;
    tick(RETRY_WAIT_CYCLES + 200);
    chkBit(channelEnable, 1'b0);
    wrCmd(CMD_CLEAR_FAULTS, 8'h00);
    chkBit(hostAlertN, 1'b1);
    chkBit(channelLatched, 1'b1);
    rdCmd(CMD_STATUS_BYTE, rd);
    chkVal({8'h00, rd[7:0]}, 16'h0040);
    channelOnPin = 1'b0;
    waitSig(1, 1'b0, 20);
    chkBit(channelLatched, 1'b0);
    channelOnPin = 1'b1;
    waitSig(0, 1'b1, 20);
    chkBit(channelEnable, 1'b1);
    // Sequenced turn-off with a random delay.
    seqOffMode = 1'b1;
    toffDelayCycles = 16'(5 + $urandom_range(19));
    wrCmd(CMD_UT_REACTION, 8'h40);
    faultReq[F_UT] = 1'b1;
    for (i = 0; i < 10 && !seqOffActive; i++) tick(1);
    chkBit(seqOffActive, 1'b1);
    n = 0;
    while (channelEnable === 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    chkVal(16'(n), toffDelayCycles + 16'h0001);
    faultReq[F_UT] = 1'b0;
    tick(3);
    onOffCmdPulse = 1'b1;
    tick(1);
    onOffCmdPulse = 1'b0;
    waitSig(0, 1'b1, 20);
    chkBit(channelEnable, 1'b1);
    seqOffMode = 1'b0;
    // Start-up timeout with retries, limited to two attempts.
    wrCmd(CMD_RETRY_COUNT, 8'h02);
    wrCmd(CMD_TON_REACTION, 8'hC8);
    for (i = 0; i < 3; i++) begin
      faultReq[F_TON] = 1'b1;
      tick(4);
      faultReq[F_TON] = 1'b0;
      chkBit(channelEnable, 1'b0);
      waitSig(0, 1'b1, RETRY_WAIT_CYCLES + 100);
      chkBit(channelEnable, i < 2);
    end
    chkBit(channelLatched, 1'b1);
    biasOkPin = 1'b0;
    waitSig(1, 1'b0, 20);
    chkBit(channelLatched, 1'b0);
    biasOkPin = 1'b1;
    waitSig(0, 1'b1, 20);
    // Retry wait ends early on an off command or a shutting fault.
    faultReq[F_TON] = 1'b1;
    tick(4);
    faultReq[F_TON] = 1'b0;
    operationOn = 1'b0;
    tick(2);
    operationOn = 1'b1;
    waitSig(0, 1'b1, 20);
    chkBit(channelEnable, 1'b1);
    faultReq[F_TON] = 1'b1;
    tick(4);
    faultReq[F_TON] = 1'b0;
    tick(4);
    faultReq[F_OT] = 1'b1;
    tick(4);
    faultReq[F_OT] = 1'b0;
    tick(RETRY_WAIT_CYCLES + 20);
    chkBit(channelLatched, 1'b1);
    onOffCmdPulse = 1'b1;
    tick(1);
    onOffCmdPulse = 1'b0;
    waitSig(0, 1'b1, 20);
    // Two faults together: the one without retry wins.
    wrCmd(CMD_OT_REACTION, 8'h88);
    wrCmd(CMD_TON_REACTION, 8'h80);
    faultReq[F_OT] = 1'b1;
    faultReq[F_TON] = 1'b1;
    tick(4);
    faultReq = '0;
    tick(RETRY_WAIT_CYCLES + 100);
    chkBit(channelEnable, 1'b0);
    chkBit(channelLatched, 1'b1);
    summarize();
  end
endmodule // tb
`default_nettype wire
